// file: inc/fasc_pkg.sv
// package of register offsets, field positions, reset values and lock-map constants
// assumes an 8-bit special-function-register port and a 16-bit flash address space
package fasc_pkg;
	// ==================================================
	// register offsets on the special-function-register port
	localparam logic [7:0] ADDR_STORE_CTRL = 8'h8F;
	localparam logic [7:0] ADDR_FLASH_CTRL = 8'hB6;
	localparam logic [7:0] ADDR_ACCESS_LIMIT = 8'hB7;
	// ==================================================
	// reset values
	localparam logic [7:0] RST_STORE_CTRL = 8'h00;
	localparam logic [7:0] RST_FLASH_CTRL = 8'h80;
	localparam logic [7:0] RST_ACCESS_LIMIT = 8'h00;
	// ==================================================
	// field positions
	localparam int BIT_STORE_WE = 0;
	localparam int BIT_STORE_EE = 1;
	localparam int BIT_SCRATCH_SEL = 2;
	localparam int BIT_FLASH_WE = 0;
	localparam int BIT_READ_ALWAYS = 6;
	localparam int BIT_ONESHOT_EN = 7;
	localparam logic [7:0] MASK_STORE_CTRL = 8'h07;
	localparam logic [7:0] MASK_FLASH_CTRL = 8'hC1;
	// ==================================================
	// flash map
	localparam logic [15:0] ADDR_READ_LOCK = 16'hFDFF;
	localparam logic [15:0] ADDR_WRITE_LOCK = 16'hFDFE;
	localparam logic [15:0] LOCK_PAGE_BASE = 16'hFC00;
	localparam logic [15:0] SCRATCH_TOP = 16'h007F;
	localparam int BLOCK_SHIFT = 13;
	localparam int PAGE_SHIFT = 9;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] BLOCKED_BYTE = 8'h00;
	// flash operation kinds sent to the cell controller
	localparam logic [1:0] OP_NONE = 2'h0;
	localparam logic [1:0] OP_PROGRAM = 2'h1;
	localparam logic [1:0] OP_PAGE_ERASE = 2'h2;
	localparam logic [1:0] OP_CHIP_ERASE = 2'h3;
endpackage : fasc_pkg

// file: src/fasc_block_map.sv
// maps a flash address onto its 8 KB lock block and tests the lock bit
// assumes lock bytes are supplied as levels from the flash control domain
module fasc_block_map (
	input wire logic [15:0] addr,
	input wire logic [7:0] lockByte,
	output logic unlocked
);
	// ==================================================
	// bit n guards the block at n times 0x2000
	always_comb begin
		unlocked = lockByte[addr[15:fasc_pkg::BLOCK_SHIFT]]; // see RQ4
	end
endmodule : fasc_block_map

// file: src/fasc_flash_access.sv
// flash access and security control: control registers, software and debug-port gating
// assumes a single-cycle register port, one request per cycle, and a cell controller
// that runs the timed operation and holds opBusy high while it does
// What this block does
// RQ1: a 128-byte scratchpad sector overlays addresses 0x00 to 0x7F when selected.
// RQ2: no instruction fetch may come from the scratchpad sector.
// RQ3: software modifies flash only after write enable, and for erase, erase enable.
// RQ4: lock bytes at 0xFDFF and 0xFDFE; bit n guards the 8 KB block n.
// RQ5: a clear read-lock bit refuses debug-port reads of that block.
// RQ6: a clear write-lock bit refuses debug-port writes and erases of that block; debug erases in the lock page pass regardless.
// RQ7: the scratchpad counts as locked only when all main blocks are locked.
// RQ8: software may program the lock page but never erase it.
// RQ9: lock bits can always be read and cleared to zero.
// RQ10: debug erase at a lock byte erases all; elsewhere in lock page, that page.
// RQ11: read limit is the access limit register in the high byte, zero low.
// RQ12: upper code cannot read, write or erase below the limit; reads return zero.
// RQ13: upper code may still fetch and execute instructions in the lower partition.
// RQ14: code below the limit reads both partitions freely.
// RQ15: access limit register takes only the first write after reset; resets to zero.
// RQ16: with limit zero, every program location is readable.
// RQ17: bit 7 enables the one-shot sense timer, bit 6 forces read mode; bit 7 resets one.
// RQ18: software writes and erases need the flash write enable bit set.
// RQ19: bits 5 to 1 of flash control are written zero and read zero.
// RQ20: with scratchpad select set, software reads and writes go to the scratchpad.
// RQ21: erase enable plus write enable makes a data-move write erase the page.
// RQ22: write enable alone makes a data-move write program one byte.
// RQ23: data-move reads always go to data RAM; flash is read by table reads.
// RQ24: 512-byte pages; erase sets every byte of the page to 0xFF.
// RQ25: the core stalls while a flash write or erase runs.
// RQ26: the partition check uses the executing instruction address.
module fasc_flash_access #(
	parameter int ADDR_W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	// special-function-register port
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regHit,
	// processor core
	input wire logic [15:0] execAddr,
	input wire logic fetchReq,
	input wire logic tableReadReq,
	input wire logic dataMoveWrite,
	input wire logic dataMoveRead,
	input wire logic [15:0] cpuAddr,
	input wire logic [7:0] cpuWdata,
	output logic [7:0] cpuRdata,
	output logic cpuRdataValid,
	output logic dataToRam,
	output logic fetchFault,
	output logic cpuStall,
	// debug-port programming path
	input wire logic dbgRead,
	input wire logic dbgWrite,
	input wire logic dbgErase,
	input wire logic [15:0] dbgAddr,
	input wire logic [7:0] dbgWdata,
	output logic [7:0] dbgRdata,
	output logic dbgRdataValid,
	output logic dbgRefused,
	// flash cell controller
	input wire logic [7:0] cellRdata,
	input wire logic [7:0] readLockByte,
	input wire logic [7:0] writeLockByte,
	input wire logic opBusy,
	output logic [1:0] opKind,
	output logic opStart,
	output logic [15:0] opAddr,
	output logic [7:0] opData,
	output logic opScratch,
	output logic senseOneShot,
	output logic senseAlways
);
	// ==================================================
	// elaboration check
	if (ADDR_W != 16) begin : g_bad_width
		$error("fasc_flash_access supports only a 16-bit flash address");
	end
	typedef enum logic [2:0] {
		FASC_IDLE = 3'b001,
		FASC_ISSUE = 3'b010,
		FASC_BUSY = 3'b100
	} fasc_state_e;
	// page test used by software and debug paths
	function automatic logic inLockPage(input logic [15:0] a);
		inLockPage = (a[15:fasc_pkg::PAGE_SHIFT] ==
			fasc_pkg::LOCK_PAGE_BASE[15:fasc_pkg::PAGE_SHIFT]);
	endfunction : inLockPage
	logic [7:0] storeCtrl_r, storeCtrl_nxt, flashCtrl_r, flashCtrl_nxt, limit_r, limit_nxt;
	logic [7:0] regRdata_r, regRdata_nxt, opData_r, opData_nxt, cpuRdata_r, cpuRdata_nxt;
	logic [7:0] dbgRdata_r, dbgRdata_nxt;
	logic limitWritten_r, limitWritten_nxt, regHit_r, regHit_nxt, opScratch_r, opScratch_nxt;
	logic cpuValid_r, cpuValid_nxt, ram_r, ram_nxt, fetchFault_r, fetchFault_nxt;
	logic dbgValid_r, dbgValid_nxt, dbgRefused_r, dbgRefused_nxt, stall_r, stall_nxt;
	fasc_state_e state_r, state_nxt;
	logic [1:0] opKind_r, opKind_nxt;
	logic [15:0] opAddr_r, opAddr_nxt;
	logic cpuPermit, dbgReadOk, dbgWriteOk, dbgScratch, dbgReadPass, dbgWritePass;
	logic storeWe, storeEe, scratchSel, flashWe;
	logic allLocked, lockByteAddr, clearOnly;
	assign storeWe = storeCtrl_r[fasc_pkg::BIT_STORE_WE];
	assign storeEe = storeCtrl_r[fasc_pkg::BIT_STORE_EE];
	assign scratchSel = storeCtrl_r[fasc_pkg::BIT_SCRATCH_SEL];
	assign flashWe = flashCtrl_r[fasc_pkg::BIT_FLASH_WE];
	// scratchpad follows the main array only once every block is locked
	assign allLocked = (readLockByte == 8'h00) && (writeLockByte == 8'h00); // see RQ7
	// debug access to the selected scratchpad obeys the combined lock, not a block bit
	assign dbgScratch = scratchSel && (dbgAddr <= fasc_pkg::SCRATCH_TOP);
	assign dbgReadPass = dbgScratch ? !allLocked : dbgReadOk; // see RQ7
	assign dbgWritePass = dbgScratch ? !allLocked : dbgWriteOk; // see RQ7
	fasc_limit_check u_limit (
		.limitHigh(limit_r),
		.execAddr(execAddr),
		.dataAddr(cpuAddr),
		.permitted(cpuPermit)
	);
	fasc_block_map u_read_map (
		.addr(dbgAddr),
		.lockByte(readLockByte),
		.unlocked(dbgReadOk)
	);
	fasc_block_map u_write_map (
		.addr(dbgAddr),
		.lockByte(writeLockByte),
		.unlocked(dbgWriteOk)
	);
	// ==================================================
	// control registers
	always_comb begin
		storeCtrl_nxt = storeCtrl_r;
		flashCtrl_nxt = flashCtrl_r;
		limit_nxt = limit_r;
		limitWritten_nxt = limitWritten_r;
		regRdata_nxt = 8'h00;
		regHit_nxt = 1'b0;
		if (regWrite && regAddr == fasc_pkg::ADDR_STORE_CTRL) begin
			storeCtrl_nxt = regWdata & fasc_pkg::MASK_STORE_CTRL;
		end else if (regWrite && regAddr == fasc_pkg::ADDR_FLASH_CTRL) begin
			// reserved bits are dropped so they always read zero
			flashCtrl_nxt = regWdata & fasc_pkg::MASK_FLASH_CTRL; // see RQ19 see RQ17
		end else if (regWrite && regAddr == fasc_pkg::ADDR_ACCESS_LIMIT) begin
			if (!limitWritten_r) begin
				limit_nxt = regWdata; // see RQ15
			end
			limitWritten_nxt = 1'b1;
		end
		if (regRead && regAddr == fasc_pkg::ADDR_STORE_CTRL) begin
			regRdata_nxt = storeCtrl_r;
			regHit_nxt = 1'b1;
		end else if (regRead && regAddr == fasc_pkg::ADDR_FLASH_CTRL) begin
			regRdata_nxt = flashCtrl_r;
			regHit_nxt = 1'b1;
		end else if (regRead && regAddr == fasc_pkg::ADDR_ACCESS_LIMIT) begin
			regRdata_nxt = limit_r;
			regHit_nxt = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			storeCtrl_r <= fasc_pkg::RST_STORE_CTRL;
			flashCtrl_r <= fasc_pkg::RST_FLASH_CTRL;
			limit_r <= fasc_pkg::RST_ACCESS_LIMIT; // see RQ16
			limitWritten_r <= 1'b0;
			regRdata_r <= 8'h00;
			regHit_r <= 1'b0;
		end else begin
			storeCtrl_r <= storeCtrl_nxt;
			flashCtrl_r <= flashCtrl_nxt;
			limit_r <= limit_nxt;
			limitWritten_r <= limitWritten_nxt;
			regRdata_r <= regRdata_nxt;
			regHit_r <= regHit_nxt;
		end
	end
	// ==================================================
	// access arbitration; a running operation blocks every new request
	always_comb begin
		state_nxt = state_r;
		opKind_nxt = opKind_r;
		opAddr_nxt = opAddr_r;
		opData_nxt = opData_r;
		opScratch_nxt = opScratch_r;
		cpuRdata_nxt = 8'h00;
		cpuValid_nxt = 1'b0;
		ram_nxt = 1'b0;
		fetchFault_nxt = 1'b0;
		dbgRdata_nxt = 8'h00;
		dbgValid_nxt = 1'b0;
		dbgRefused_nxt = 1'b0;
		lockByteAddr = (dbgAddr == fasc_pkg::ADDR_READ_LOCK) ||
			(dbgAddr == fasc_pkg::ADDR_WRITE_LOCK);
		// programming only clears bits, so a lock byte write can always add locks
		clearOnly = lockByteAddr && dbgWrite; // see RQ9
		case (state_r)
			FASC_IDLE: begin
				// scratchpad never executes; other fetches are never partition-gated, see RQ13
				fetchFault_nxt = fetchReq && scratchSel && (cpuAddr <= fasc_pkg::SCRATCH_TOP); // see RQ2
				if (dataMoveRead) begin
					ram_nxt = 1'b1; // see RQ23
				end else if (tableReadReq) begin
					cpuValid_nxt = 1'b1;
					// scratchpad read uses opScratch-free path: cell answers per select
					cpuRdata_nxt = cpuPermit ? cellRdata : fasc_pkg::BLOCKED_BYTE; // see RQ12 see RQ20
				end else if (dataMoveWrite) begin
					if (!(storeWe && flashWe)) begin
						ram_nxt = 1'b1; // see RQ3 see RQ18
					end else if (cpuPermit && !(storeEe && inLockPage(cpuAddr) && !scratchSel)) begin
						opKind_nxt = storeEe ? fasc_pkg::OP_PAGE_ERASE : fasc_pkg::OP_PROGRAM; // see RQ21 see RQ22 see RQ24
						opAddr_nxt = cpuAddr;
						opData_nxt = cpuWdata;
						opScratch_nxt = scratchSel; // see RQ1 see RQ20
						state_nxt = FASC_ISSUE;
					end
					// lock page erase and writes below the limit are silently dropped; see RQ8 see RQ12
				end else if (dbgRead) begin
					dbgValid_nxt = 1'b1;
					// lock bytes stay readable; locked blocks read as undefined, here 0xFF
					if (dbgReadPass || lockByteAddr) begin // see RQ5 see RQ9
						dbgRdata_nxt = cellRdata;
					end else begin
						dbgRdata_nxt = fasc_pkg::ERASED_BYTE;
						dbgRefused_nxt = 1'b1;
					end
				end else if (dbgErase && lockByteAddr) begin
					opKind_nxt = fasc_pkg::OP_CHIP_ERASE; // see RQ10
					opAddr_nxt = dbgAddr;
					opScratch_nxt = 1'b0;
					state_nxt = FASC_ISSUE;
				end else if (dbgErase && (inLockPage(dbgAddr) || dbgWritePass)) begin
					opKind_nxt = fasc_pkg::OP_PAGE_ERASE; // see RQ10 see RQ6
					opAddr_nxt = dbgAddr;
					opScratch_nxt = dbgScratch; // see RQ7
					state_nxt = FASC_ISSUE;
				end else if (dbgWrite && (dbgWritePass || clearOnly)) begin
					opKind_nxt = fasc_pkg::OP_PROGRAM; // see RQ6
					opAddr_nxt = dbgAddr;
					opData_nxt = dbgWdata;
					opScratch_nxt = dbgScratch; // see RQ7
					state_nxt = FASC_ISSUE;
				end else if (dbgWrite || dbgErase) begin
					dbgRefused_nxt = 1'b1;
				end
			end
			FASC_ISSUE: state_nxt = FASC_BUSY;
			FASC_BUSY: begin
				if (!opBusy) begin
					opKind_nxt = fasc_pkg::OP_NONE;
					state_nxt = FASC_IDLE;
				end
			end
			default: state_nxt = FASC_IDLE;
		endcase
		stall_nxt = (state_nxt != FASC_IDLE); // registered so the stall output is a flop
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= FASC_IDLE;
			stall_r <= 1'b0;
			opKind_r <= fasc_pkg::OP_NONE;
			opAddr_r <= 16'h0000;
			opData_r <= 8'h00;
			opScratch_r <= 1'b0;
			cpuRdata_r <= 8'h00;
			cpuValid_r <= 1'b0;
			ram_r <= 1'b0;
			fetchFault_r <= 1'b0;
			dbgRdata_r <= 8'h00;
			dbgValid_r <= 1'b0;
			dbgRefused_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			stall_r <= stall_nxt;
			opKind_r <= opKind_nxt;
			opAddr_r <= opAddr_nxt;
			opData_r <= opData_nxt;
			opScratch_r <= opScratch_nxt;
			cpuRdata_r <= cpuRdata_nxt;
			cpuValid_r <= cpuValid_nxt;
			ram_r <= ram_nxt;
			fetchFault_r <= fetchFault_nxt;
			dbgRdata_r <= dbgRdata_nxt;
			dbgValid_r <= dbgValid_nxt;
			dbgRefused_r <= dbgRefused_nxt;
		end
	end
	// ==================================================
	// outputs, all from flip-flops
	assign regRdata = regRdata_r;
	assign regHit = regHit_r;
	assign cpuRdata = cpuRdata_r;
	assign cpuRdataValid = cpuValid_r;
	assign dataToRam = ram_r;
	assign fetchFault = fetchFault_r;
	assign cpuStall = stall_r; // see RQ25
	assign dbgRdata = dbgRdata_r;
	assign dbgRdataValid = dbgValid_r;
	assign dbgRefused = dbgRefused_r;
	assign opKind = opKind_r;
	assign opStart = state_r[1]; // issue bit of the one-hot state
	assign opAddr = opAddr_r;
	assign opData = opData_r;
	assign opScratch = opScratch_r;
	assign senseOneShot = flashCtrl_r[fasc_pkg::BIT_ONESHOT_EN]; // see RQ17
	assign senseAlways = flashCtrl_r[fasc_pkg::BIT_READ_ALWAYS];
	// ==================================================
	// checks
	a_limit_once: assert property (@(posedge clk) disable iff (sys_rst)
		limitWritten_r |=> $stable(limit_r)) // see RQ15
		else $error("access limit changed after its first write");
	a_store_gate: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == FASC_IDLE && dataMoveWrite && !dataMoveRead && !tableReadReq && !flashWe)
		|=> state_r == FASC_IDLE) // see RQ18
		else $error("flash operation started without write enable");
	a_blocked_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == FASC_IDLE && tableReadReq && !dataMoveRead && !cpuPermit)
		|=> cpuRdataValid && cpuRdata == 8'h00) // see RQ12
		else $error("read below limit not returned as zero");
	a_stall_op: assert property (@(posedge clk) disable iff (sys_rst)
		opStart |=> cpuStall) // see RQ25
		else $error("core not stalled during flash operation");
	a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
		flashCtrl_r[5:1] == 5'h00) // see RQ19
		else $error("reserved flash control bits not zero");
	a_ram_read: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == FASC_IDLE && dataMoveRead) |=> dataToRam && !cpuRdataValid) // see RQ23
		else $error("data-move read reached flash");
	a_issue_seq: assert property (@(posedge clk) disable iff (sys_rst)
		opStart |=> !opStart ##0 state_r == FASC_BUSY) // see RQ25
		else $error("operation start not a single pulse");
	a_dbg_lock: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == FASC_IDLE && dbgRead && !dataMoveRead && !tableReadReq && !dataMoveWrite
		&& !dbgReadPass && !lockByteAddr) |=> dbgRefused) // see RQ5
		else $error("read-locked debug read not refused");
endmodule : fasc_flash_access

// file: src/fasc_limit_check.sv
// partition check of a data access against the software read limit
// assumes the caller supplies the address of the currently executing instruction
module fasc_limit_check (
	input wire logic [7:0] limitHigh,
	input wire logic [15:0] execAddr,
	input wire logic [15:0] dataAddr,
	output logic permitted
);
	logic [15:0] readLimit;
	// ==================================================
	// limit is the register in the high byte, zero low
	always_comb begin
		readLimit = {limitHigh, 8'h00}; // see RQ11 see RQ16
		// lower code sees all; upper code sees only the upper partition
		permitted = (execAddr < readLimit) || (dataAddr >= readLimit); // see RQ26 see RQ14
	end
endmodule : fasc_limit_check

// file: test/fasc_cell_model.sv
// behavioural flash cell controller facing the access and security block
// assumes one clock domain and a busy length held steady by the bench
module fasc_cell_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic opStart,
	input wire logic [15:0] rdAddr,
	input wire logic [7:0] busyLen,
	output logic [7:0] cellRdata,
	output logic opBusy
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==================================================
	// array contents
	logic [7:0] busyCnt_r;
	logic [7:0] busyCnt_nxt;
	// address-dependent pattern so a wrong address shows up as wrong data
	assign cellRdata = rdAddr[7:0] ^ rdAddr[15:8] ^ 8'h5A;
	// ==================================================
	// timed operation
	// a zero length answers at once, a longer one holds opBusy high for busyLen cycles
	always_comb begin
		busyCnt_nxt = busyCnt_r;
		if (opStart) begin
			busyCnt_nxt = busyLen;
		end else if (busyCnt_r != 8'h00) begin
			busyCnt_nxt = busyCnt_r - 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busyCnt_r <= 8'h00;
		end else begin
			busyCnt_r <= busyCnt_nxt;
		end
	end
	assign opBusy = (busyCnt_r != 8'h00);
endmodule : fasc_cell_model

// file: test/flash_access_security_control_test.sv
// self-checking bench for the flash access and security block
// assumes the cell model stands in for the flash array and its timer
module flash_access_security_control_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, sys_rst, regWrite, regRead, regHit, fetchReq, tableReadReq, dataMoveWrite;
	logic dataMoveRead, cpuRdataValid, dataToRam, fetchFault, cpuStall, dbgRead, dbgWrite;
	logic dbgErase, dbgRdataValid, dbgRefused, opBusy, opStart, opScratch;
	logic senseOneShot, senseAlways;
	logic [7:0] regAddr, regWdata, regRdata, cpuWdata, cpuRdata, dbgWdata, dbgRdata, cellRdata;
	logic [7:0] readLockByte, writeLockByte, opData, busyLen;
	logic [15:0] execAddr, cpuAddr, dbgAddr, opAddr;
	logic [1:0] opKind;
	int fails, total_checks, n;
	fasc_flash_access u_dut (.clk(clk), .sys_rst(sys_rst), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.regHit(regHit), .execAddr(execAddr), .fetchReq(fetchReq), .tableReadReq(tableReadReq),
		.dataMoveWrite(dataMoveWrite), .dataMoveRead(dataMoveRead), .cpuAddr(cpuAddr),
		.cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .cpuRdataValid(cpuRdataValid),
		.dataToRam(dataToRam), .fetchFault(fetchFault), .cpuStall(cpuStall), .dbgRead(dbgRead),
		.dbgWrite(dbgWrite), .dbgErase(dbgErase), .dbgAddr(dbgAddr), .dbgWdata(dbgWdata),
		.dbgRdata(dbgRdata), .dbgRdataValid(dbgRdataValid), .dbgRefused(dbgRefused),
		.cellRdata(cellRdata), .readLockByte(readLockByte), .writeLockByte(writeLockByte),
		.opBusy(opBusy), .opKind(opKind), .opStart(opStart), .opAddr(opAddr), .opData(opData),
		.opScratch(opScratch), .senseOneShot(senseOneShot), .senseAlways(senseAlways));
	fasc_cell_model u_cell (.clk(clk), .sys_rst(sys_rst), .opStart(opStart), .rdAddr(cpuAddr),
		.busyLen(busyLen), .cellRdata(cellRdata), .opBusy(opBusy));
	// ==================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
	// ==================================================
	// helpers
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : pat
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	// register port, one level strobe per cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 regWrite = 1'b1;
		regAddr = a;
		regWdata = d;
		@(posedge clk);
		#1 regWrite = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		@(posedge clk);
		#1 regRead = 1'b1;
		regAddr = a;
		@(posedge clk);
		#1 regRead = 1'b0;
		check(regHit, hit);
		if (hit) check(regRdata, exp);
	endtask : rd
	// one request pulse; answers are looked at in the cycle right after it
	// k: 0 table read, 1 data-move write, 2 data-move read, 3 fetch, 4..6 debug r/w/e
	task automatic op(input int k, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 cpuAddr = a;
		dbgAddr = a;
		cpuWdata = d;
		dbgWdata = d;
		tableReadReq = (k == 0);
		dataMoveWrite = (k == 1);
		dataMoveRead = (k == 2);
		fetchReq = (k == 3);
		dbgRead = (k == 4);
		dbgWrite = (k == 5);
		dbgErase = (k == 6);
		@(posedge clk);
		#1 {tableReadReq, dataMoveWrite, dataMoveRead, fetchReq} = 4'h0;
		{dbgRead, dbgWrite, dbgErase} = 3'h0;
	endtask : op
	// expect a started cell operation, then wait for the stall to end
	task automatic expop(input logic [1:0] kind);
		check(opStart, 1'b1);
		check(opKind, kind);
		check(cpuStall, 1'b1);
		for (n = 0; n < 50 && cpuStall !== 1'b0; n++) begin
			@(posedge clk);
			#1;
		end
		check(cpuStall, 1'b0);
	endtask : expop
	// ==================================================
	// test sequence
	initial begin
		{regWrite, regRead, fetchReq, tableReadReq, dataMoveWrite, dataMoveRead} = 6'h00;
		{dbgRead, dbgWrite, dbgErase} = 3'h0;
		{regAddr, regWdata, cpuWdata, dbgWdata, busyLen} = 40'h00_0000_0000;
		{execAddr, cpuAddr, dbgAddr} = 48'h0000_0000_0000;
		readLockByte = 8'hFF;
		writeLockByte = 8'hFF;
		fails = 0;
		total_checks = 0;
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 sys_rst = 1'b0;
		check(senseOneShot, 1'b1);
		rd(fasc_pkg::ADDR_STORE_CTRL, 8'h00, 1'b1);
		rd(fasc_pkg::ADDR_FLASH_CTRL, 8'h80, 1'b1);
		rd(fasc_pkg::ADDR_ACCESS_LIMIT, 8'h00, 1'b1);
		rd(8'h90, 8'h00, 1'b0);
		// default limit, top code reads the very bottom
		execAddr = 16'hF000;
		op(0, 16'h0000, 8'h00);
		check(cpuRdata, pat(16'h0000));
		op(1, 16'h1234, 8'hA5);
		check(dataToRam, 1'b1);
		check(opStart, 1'b0);
		// ones into the reserved bits on purpose, they must read back zero
		wr(fasc_pkg::ADDR_FLASH_CTRL, 8'hFF);
		rd(fasc_pkg::ADDR_FLASH_CTRL, 8'hC1, 1'b1);
		check(senseAlways, 1'b1);
		wr(fasc_pkg::ADDR_STORE_CTRL, 8'h01);
		op(1, 16'h1234, 8'h3C);
		check(opAddr, 16'h1234);
		check(opData, 8'h3C);
		expop(fasc_pkg::OP_PROGRAM);
		busyLen = 8'h06;
		op(2, 16'h1234, 8'h00);
		check(dataToRam, 1'b1);
		wr(fasc_pkg::ADDR_STORE_CTRL, 8'h03);
		op(1, 16'h4321, 8'h00);
		expop(fasc_pkg::OP_PAGE_ERASE);
		op(1, 16'hFD00, 8'h00);
		check(opStart, 1'b0);
		wr(fasc_pkg::ADDR_STORE_CTRL, 8'h01);
		op(1, 16'hFDFE, 8'h7F);
		expop(fasc_pkg::OP_PROGRAM);
		wr(fasc_pkg::ADDR_FLASH_CTRL, 8'hC0);
		op(1, 16'h1000, 8'h01);
		check(opStart, 1'b0);
		wr(fasc_pkg::ADDR_FLASH_CTRL, 8'h01);
		// the limit register keeps only its first write
		wr(fasc_pkg::ADDR_ACCESS_LIMIT, 8'h40);
		wr(fasc_pkg::ADDR_ACCESS_LIMIT, 8'h80);
		rd(fasc_pkg::ADDR_ACCESS_LIMIT, 8'h40, 1'b1);
		execAddr = 16'h5000;
		op(0, 16'h3FFF, 8'h00);
		check(cpuRdata, 8'h00);
		op(0, 16'h4000, 8'h00);
		check(cpuRdata, pat(16'h4000));
		check(cpuRdataValid, 1'b1);
		op(3, 16'h1000, 8'h00);
		check(fetchFault, 1'b0);
		op(1, 16'h1000, 8'h00);
		check(opStart, 1'b0);
		execAddr = 16'h1000;
		op(0, 16'h0800, 8'h00);
		check(cpuRdata, pat(16'h0800));
		op(0, 16'h8000, 8'h00);
		check(cpuRdata, pat(16'h8000));
		// scratchpad selected: no fetch from it, writes go to it
		wr(fasc_pkg::ADDR_STORE_CTRL, 8'h05);
		op(3, 16'h0010, 8'h00);
		check(fetchFault, 1'b1);
		op(1, 16'h0020, 8'h11);
		check(opScratch, 1'b1);
		expop(fasc_pkg::OP_PROGRAM);
		wr(fasc_pkg::ADDR_STORE_CTRL, 8'h00);
		// each read-lock bit refuses debug reads in its own 8 KB block; the next block's read is only checked for a valid answer
		for (int b = 0; b < 8; b++) begin
			readLockByte = ~(8'h01 << b);
			op(4, 16'(b) * 16'h2000 + 16'h0010, 8'h00);
			check(dbgRefused, 1'b1);
			check(dbgRdata, 8'hFF);
			op(4, 16'((b + 1) % 8) * 16'h2000 + 16'h0010, 8'h00);
			check(dbgRdataValid, 1'b1);
		end
		writeLockByte = 8'h7F;
		op(5, 16'hE000, 8'h12);
		check(dbgRefused, 1'b1);
		check(opStart, 1'b0);
		op(5, 16'hFDFF, 8'h00);
		expop(fasc_pkg::OP_PROGRAM);
		writeLockByte = 8'hFF;
		op(6, 16'hFDFE, 8'h00);
		expop(fasc_pkg::OP_CHIP_ERASE);
		op(6, 16'hFC10, 8'h00);
		expop(fasc_pkg::OP_PAGE_ERASE);
		// selected scratchpad ignores block 0 locks until every block is locked
		wr(fasc_pkg::ADDR_STORE_CTRL, 8'h04);
		readLockByte = 8'hFE;
		op(4, 16'h0010, 8'h00);
		check(dbgRdata, pat(16'h0010));
		{readLockByte, writeLockByte} = 16'h0000;
		op(4, 16'h0010, 8'h00);
		check(dbgRefused, 1'b1);
		op(5, 16'h0020, 8'h00);
		check(opStart, 1'b0);
		writeLockByte = 8'hFE;
		op(5, 16'h0020, 8'h33);
		check(opScratch, 1'b1);
		expop(fasc_pkg::OP_PROGRAM);
		// a second reset re-arms the one-time limit write
		sys_rst = 1'b1;
		repeat (3) @(posedge clk);
		#1 sys_rst = 1'b0;
		check(senseOneShot, 1'b1);
		rd(fasc_pkg::ADDR_ACCESS_LIMIT, 8'h00, 1'b1);
		wr(fasc_pkg::ADDR_ACCESS_LIMIT, 8'h20);
		rd(fasc_pkg::ADDR_ACCESS_LIMIT, 8'h20, 1'b1);
		report_and_stop();
	end
endmodule : flash_access_security_control_test
